// ### omsc_top.sv
`timescale 1ns/1ns
`include "omsc_map.svh"
// What this block does
// - debug pin high: watchdog off, all else runs, CAN transmitter on.
// - debug pin low ends debug; watchdog restarts with long open window.
// - standby command acts at chip select rising edge, entry immediate.
// - bit0 target select, bit1 request; 11 primary, 10 battery, 0x none.
// - monitor enabled: long window on entry, watchdog off at low current.
// - monitor disabled: watchdog off at entry, current not watched.
// - monitor disable may be set only right after an unlock frame.
// - unlock bit clears itself on the next serial frame.
// - primary standby: regulator on; outputs, LIN, CAN transmitters off.
// - primary standby keeps both switches and secondary regulator set.
// - wake in primary standby: interrupt low 56 us after reaction delay.
// - standby control bits keep their last value after wake-up.
// - battery standby: both regulators, outputs, LIN, CAN off.
// - battery standby keeps both always-on switches as programmed.
// - wake from battery standby pulses the system reset output.
// - monitor enabled: current rising above threshold restarts watchdog.
// - battery wake reset pulse lasts 2 ms; primary wake uses interrupt.
// - disabling both LIN and CAN wake is refused, defaults, error set.
// - chip select falling edge wakes every standby except battery.
module omsc_top
  import omsc_pkg::*;
#(
  parameter int REACT_CYC =
    (`OMSC_REACT_NS + `OMSC_CLK_NS - 1) / `OMSC_CLK_NS,
  parameter int INT_PULSE_CYC = `OMSC_INT_PULSE_NS / `OMSC_CLK_NS,
  parameter int RST_PULSE_CYC = `OMSC_RST_PULSE_NS / `OMSC_CLK_NS
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic       link_sclk_i,
  input  wire logic       link_csn_i,
  input  wire logic       link_mosi_i,
  input  wire logic       debug_high_i,
  input  wire logic       debug_low_i,
  input  wire logic       load_high_i,
  input  wire logic       lin_wake_i,
  input  wire logic       can_wake_i,
  input  wire logic       timer_wake_i,
  input  wire logic       serial_error_clear_i,
  output logic [1:0]      mode_o,
  output logic [1:0]      standby_control_word_o,
  output logic            watchdog_enable_o,
  output logic            watchdog_restart_o,
  output logic            primary_regulator_on_o,
  output logic            secondary_regulator_on_o,
  output logic            always_on_switch_a_o,
  output logic            always_on_switch_b_o,
  output logic            power_outputs_on_o,
  output logic            lin_tx_enable_o,
  output logic            can_tx_enable_o,
  output logic            wake_interrupt_n_o,
  output logic            system_reset_out_n_o,
  output logic            serial_error_flag_o,
  output logic            monitor_disable_o
);

  // link side: shift register on the host clock only
  logic [`OMSC_FRAME_BITS-1:0] link_shift_ff;

  always_ff @(posedge link_sclk_i) begin
    if (!link_csn_i) begin
      link_shift_ff <= {link_shift_ff[`OMSC_FRAME_BITS-2:0], link_mosi_i};
    end
  end

  // pins into the core clock
  logic [6:0] pin_s;
  logic       csn_s;
  logic       dbg_high_s;
  logic       dbg_low_s;
  logic       load_s;
  logic       lin_s;
  logic       can_s;
  logic       tmr_s;

  omsc_sync #(
    .W    (7),
    .INIT (`OMSC_SYNC_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .d_i     ({timer_wake_i, can_wake_i, lin_wake_i, load_high_i,
               debug_low_i, debug_high_i, link_csn_i}),
    .q_o     (pin_s)
  );

  assign {tmr_s, can_s, lin_s, load_s, dbg_low_s, dbg_high_s, csn_s} = pin_s;

  omsc_state_t cur_ff;
  omsc_state_t nxt_ff;

  omsc_timer_if int_tif ();
  omsc_timer_if rst_tif ();

  assign int_tif.start = cur_ff.int_start;
  assign rst_tif.start = cur_ff.rst_start;

  omsc_pulse_timer #(
    .DELAY_CYC (REACT_CYC),
    .PULSE_CYC (INT_PULSE_CYC)
  ) u_int_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .tif     (int_tif.timer)
  );

  omsc_pulse_timer #(
    .DELAY_CYC (0),
    .PULSE_CYC (RST_PULSE_CYC)
  ) u_rst_timer (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .tif     (rst_tif.timer)
  );

  // the shift register is still while chip select is high, since the
  // host clock stops between frames; sampling it after the synchronised
  // rising edge is therefore safe
  logic       frame_done;
  logic       csn_fall;
  logic [1:0] wsel;
  logic [5:0] fdata;
  logic       lin_wu;
  logic       can_wu;
  logic       wake_v1;
  logic       wake_vbat;

  assign frame_done = csn_s & ~cur_ff.csn_q;
  assign csn_fall   = ~csn_s & cur_ff.csn_q;
  assign wsel  = link_shift_ff[`OMSC_WSEL_HI:`OMSC_WSEL_LO];
  assign fdata = link_shift_ff[5:0];
  assign lin_wu = lin_s & cur_ff.wake_cfg[`OMSC_LINWU_BIT];
  assign can_wu = can_s & cur_ff.wake_cfg[`OMSC_CANWU_BIT];
  assign wake_v1   = lin_wu | can_wu | tmr_s | csn_fall;
  assign wake_vbat = lin_wu | can_wu | tmr_s;

  always_comb begin
    nxt_ff = cur_ff;
    if (reset_i) begin
      nxt_ff = '{mode: OMSC_ACTIVE, stby_word: `OMSC_STBY_RST,
                 unlock: 1'b0, mon_dis: 1'b0, cfg1: `OMSC_CFG1_RST,
                 wake_cfg: `OMSC_WAKE_RST, ser_err: 1'b0, wd_en: 1'b1,
                 wd_restart: 1'b0, csn_q: 1'b1, load_q: 1'b0,
                 reg1_on: 1'b1, reg2_on: 1'b0, swa_on: 1'b0,
                 swb_on: 1'b0, pout_on: 1'b0, lin_tx: 1'b1,
                 can_tx: 1'b1, int_n: 1'b1, rst_n: 1'b1,
                 int_start: 1'b0, rst_start: 1'b0};
    end else begin
      nxt_ff.csn_q      = csn_s;
      nxt_ff.load_q     = load_s;
      nxt_ff.wd_restart = 1'b0;
      nxt_ff.int_start  = 1'b0;
      nxt_ff.rst_start  = 1'b0;
      if (serial_error_clear_i) begin
        nxt_ff.ser_err = 1'b0;
      end

      if (frame_done) begin
        nxt_ff.unlock = 1'b0;
        case (wsel)
          `OMSC_W_STBY: begin
            nxt_ff.stby_word = fdata[1:0];
            if (fdata[`OMSC_STBY_REQ_BIT] && cur_ff.mode == OMSC_ACTIVE) begin
              if (fdata[`OMSC_STANDBY_TARGET_SELECT_BIT]) begin
                nxt_ff.mode = OMSC_V1_STBY;
                nxt_ff.wd_en = ~cur_ff.mon_dis;
                nxt_ff.wd_restart = ~cur_ff.mon_dis;
              end else begin
                nxt_ff.mode  = OMSC_VBAT_STBY;
                nxt_ff.wd_en = 1'b0;
              end
            end
          end
          `OMSC_W_CFG1: begin
            nxt_ff.unlock = fdata[`OMSC_UNLOCK_BIT];
            nxt_ff.cfg1   = fdata[`OMSC_CFG1_HI:`OMSC_CFG1_LO];
          end
          `OMSC_W_CFG2: begin
            // a one only sticks right behind an unlock frame
            if (!fdata[`OMSC_MONDIS_BIT]) begin
              nxt_ff.mon_dis = 1'b0;
            end else if (cur_ff.unlock) begin
              nxt_ff.mon_dis = 1'b1;
            end
          end
          `OMSC_W_WAKE: begin
            // a refused word leaves the transmitter bits alone as well
            if (fdata[1:0] == 2'h0) begin
              nxt_ff.wake_cfg[1:0] = `OMSC_WU_DEF;
              nxt_ff.ser_err = 1'b1;
            end else begin
              nxt_ff.wake_cfg = fdata[3:0];
            end
          end
          default: begin
            nxt_ff.unlock = 1'b0;
          end
        endcase
      end

      case (cur_ff.mode)
        OMSC_ACTIVE: begin
          if (dbg_high_s) begin
            nxt_ff.mode  = OMSC_DEBUG;
            nxt_ff.wd_en = 1'b0;
          end
        end
        OMSC_DEBUG: begin
          if (dbg_low_s) begin
            nxt_ff.mode       = OMSC_ACTIVE;
            nxt_ff.wd_en      = 1'b1;
            nxt_ff.wd_restart = 1'b1;
          end
        end
        OMSC_V1_STBY: begin
          if (wake_v1) begin
            nxt_ff.mode       = OMSC_ACTIVE;
            nxt_ff.int_start  = 1'b1;
            nxt_ff.wd_en      = 1'b1;
            nxt_ff.wd_restart = 1'b1;
          end else if (!cur_ff.mon_dis) begin
            if (load_s && !cur_ff.load_q) begin
              nxt_ff.wd_en      = 1'b1;
              nxt_ff.wd_restart = 1'b1;
            end else if (!load_s && !cur_ff.wd_restart) begin
              nxt_ff.wd_en = 1'b0;
            end
          end
        end
        OMSC_VBAT_STBY: begin
          if (wake_vbat) begin
            nxt_ff.mode       = OMSC_ACTIVE;
            nxt_ff.rst_start  = 1'b1;
            nxt_ff.wd_en      = 1'b1;
            nxt_ff.wd_restart = 1'b1;
          end
        end
        default: begin
          nxt_ff.mode = OMSC_ACTIVE;
        end
      endcase

      // switches follow their bits in every mode
      nxt_ff.swa_on = nxt_ff.cfg1[`OMSC_SWA_IDX];
      nxt_ff.swb_on = nxt_ff.cfg1[`OMSC_SWB_IDX];
      case (nxt_ff.mode)
        OMSC_V1_STBY: begin
          nxt_ff.reg1_on = 1'b1;
          nxt_ff.reg2_on = nxt_ff.cfg1[`OMSC_REG2_IDX];
          nxt_ff.pout_on = 1'b0;
          nxt_ff.lin_tx  = 1'b0;
          nxt_ff.can_tx  = 1'b0;
        end
        OMSC_VBAT_STBY: begin
          nxt_ff.reg1_on = 1'b0;
          nxt_ff.reg2_on = 1'b0;
          nxt_ff.pout_on = 1'b0;
          nxt_ff.lin_tx  = 1'b0;
          nxt_ff.can_tx  = 1'b0;
        end
        default: begin
          nxt_ff.reg1_on = 1'b1;
          nxt_ff.reg2_on = nxt_ff.cfg1[`OMSC_REG2_IDX];
          nxt_ff.pout_on = nxt_ff.cfg1[`OMSC_POUT_IDX];
          nxt_ff.lin_tx  = nxt_ff.wake_cfg[`OMSC_LINTX_BIT];
          nxt_ff.can_tx  = (nxt_ff.mode == OMSC_DEBUG) ? 1'b1
                         : nxt_ff.wake_cfg[`OMSC_CANTX_BIT];
        end
      endcase
      nxt_ff.int_n = ~int_tif.active;
      nxt_ff.rst_n = ~rst_tif.active;
      // a hardware set above wins over the software clear
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign mode_o                   = cur_ff.mode;
  assign standby_control_word_o   = cur_ff.stby_word;
  assign watchdog_enable_o        = cur_ff.wd_en;
  assign watchdog_restart_o       = cur_ff.wd_restart;
  assign primary_regulator_on_o   = cur_ff.reg1_on;
  assign secondary_regulator_on_o = cur_ff.reg2_on;
  assign always_on_switch_a_o     = cur_ff.swa_on;
  assign always_on_switch_b_o     = cur_ff.swb_on;
  assign power_outputs_on_o       = cur_ff.pout_on;
  assign lin_tx_enable_o          = cur_ff.lin_tx;
  assign can_tx_enable_o          = cur_ff.can_tx;
  assign wake_interrupt_n_o       = cur_ff.int_n;
  assign system_reset_out_n_o     = cur_ff.rst_n;
  assign serial_error_flag_o      = cur_ff.ser_err;
  assign monitor_disable_o        = cur_ff.mon_dis;

  localparam int A_INT_LO = 1;
  localparam int A_INT_HI = REACT_CYC + 4;

  default clocking a_cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence v1_wake_s;
    ce_i && cur_ff.mode == OMSC_V1_STBY && wake_v1;
  endsequence

  sequence int_fires_s;
    cur_ff.int_start ##[A_INT_LO:A_INT_HI] !wake_interrupt_n_o;
  endsequence

  debug_wd_off_a: assert property (
    cur_ff.mode == OMSC_DEBUG |-> !watchdog_enable_o && can_tx_enable_o)
    else $error("watchdog or can transmitter wrong in debug");

  debug_exit_a: assert property (
    ce_i && cur_ff.mode == OMSC_DEBUG && dbg_low_s |=>
      cur_ff.mode == OMSC_ACTIVE && watchdog_restart_o && watchdog_enable_o)
    else $error("debug exit did not restart watchdog");

  stby_enter_a: assert property (
    ce_i && frame_done && wsel == `OMSC_W_STBY && fdata[1:0] == 2'h3
      && cur_ff.mode == OMSC_ACTIVE && !dbg_high_s |=>
      cur_ff.mode == OMSC_V1_STBY && primary_regulator_on_o
      && !lin_tx_enable_o && !can_tx_enable_o && !power_outputs_on_o)
    else $error("primary standby not entered at frame end");

  vbat_off_a: assert property (
    cur_ff.mode == OMSC_VBAT_STBY |-> !primary_regulator_on_o
      && !secondary_regulator_on_o && !lin_tx_enable_o && !can_tx_enable_o)
    else $error("supply left on in battery standby");

  unlock_gate_a: assert property (
    ce_i && frame_done && wsel == `OMSC_W_CFG2 && !cur_ff.unlock |=>
      !(monitor_disable_o && !$past(monitor_disable_o)))
    else $error("monitor disable set without unlock");

  unlock_clear_a: assert property (
    ce_i && frame_done && wsel != `OMSC_W_CFG1 |=> !cur_ff.unlock)
    else $error("unlock bit survived a frame");

  int_pulse_a: assert property (
    v1_wake_s |=> int_fires_s)
    else $error("wake interrupt not driven after wake");

  rst_pulse_a: assert property (
    ce_i && cur_ff.mode == OMSC_VBAT_STBY && wake_vbat |=>
      cur_ff.rst_start ##2 !system_reset_out_n_o)
    else $error("no reset pulse after battery wake");

  stby_keep_a: assert property (
    v1_wake_s |=> $stable(standby_control_word_o))
    else $error("standby bits changed by wake");

  wake_reject_a: assert property (
    ce_i && frame_done && wsel == `OMSC_W_WAKE && fdata[1:0] == 2'h0 |=>
      serial_error_flag_o && cur_ff.wake_cfg[1:0] == `OMSC_WU_DEF)
    else $error("double wake disable not refused");

  mondis_wd_a: assert property (
    ce_i && frame_done && wsel == `OMSC_W_STBY && fdata[1:0] == 2'h3
      && cur_ff.mode == OMSC_ACTIVE && cur_ff.mon_dis && !dbg_high_s |=>
      !watchdog_enable_o)
    else $error("watchdog left on with monitor disabled");

endmodule

// ### omsc_map.svh
`ifndef OMSC_MAP_SVH
`define OMSC_MAP_SVH

// clock and timing, times in ns
`define OMSC_CLK_NS         4
`define OMSC_INT_PULSE_NS   56000
`define OMSC_RST_PULSE_NS   2000000
`define OMSC_REACT_NS       1000

// serial frame: [7:6] word select, [5:0] data
`define OMSC_FRAME_BITS     8
`define OMSC_WSEL_HI        7
`define OMSC_WSEL_LO        6
`define OMSC_W_STBY         2'h0
`define OMSC_W_CFG1         2'h1
`define OMSC_W_CFG2         2'h2
`define OMSC_W_WAKE         2'h3

// standby_control_word
`define OMSC_STANDBY_TARGET_SELECT_BIT   0
`define OMSC_STBY_REQ_BIT   1
`define OMSC_STBY_RST       2'h0

// config_word_one: unlock, switch a, switch b, secondary reg, outputs
`define OMSC_UNLOCK_BIT     0
`define OMSC_CFG1_LO        1
`define OMSC_CFG1_HI        4
`define OMSC_CFG1_RST       4'h0
`define OMSC_SWA_IDX        0
`define OMSC_SWB_IDX        1
`define OMSC_REG2_IDX       2
`define OMSC_POUT_IDX       3

// config_word_two
`define OMSC_MONDIS_BIT     0

// wake config: lin wake, can wake, lin tx, can tx
`define OMSC_LINWU_BIT      0
`define OMSC_CANWU_BIT      1
`define OMSC_LINTX_BIT      2
`define OMSC_CANTX_BIT      3
`define OMSC_WAKE_RST       4'hF
`define OMSC_WU_DEF         2'h3

// synchroniser reset image, link chip select idles high
`define OMSC_SYNC_RST       7'h01

`endif

// ### omsc_pkg.sv
package omsc_pkg;

  typedef enum logic [1:0] {
    OMSC_ACTIVE    = 2'b00,
    OMSC_DEBUG     = 2'b01,
    OMSC_V1_STBY   = 2'b10,
    OMSC_VBAT_STBY = 2'b11
  } omsc_mode_t;

  typedef enum logic [1:0] {
    OMSC_T_IDLE  = 2'b00,
    OMSC_T_WAIT  = 2'b01,
    OMSC_T_PULSE = 2'b10
  } omsc_tphase_t;

  typedef struct packed {
    omsc_tphase_t phase;
    logic [19:0]  cnt;
    logic         active;
  } omsc_timer_t;

  typedef struct packed {
    omsc_mode_t  mode;
    logic [1:0]  stby_word;
    logic        unlock;
    logic        mon_dis;
    logic [3:0]  cfg1;
    logic [3:0]  wake_cfg;
    logic        ser_err;
    logic        wd_en;
    logic        wd_restart;
    logic        csn_q;
    logic        load_q;
    logic        reg1_on;
    logic        reg2_on;
    logic        swa_on;
    logic        swb_on;
    logic        pout_on;
    logic        lin_tx;
    logic        can_tx;
    logic        int_n;
    logic        rst_n;
    logic        int_start;
    logic        rst_start;
  } omsc_state_t;

endpackage

// ### omsc_timer_if.sv
`timescale 1ns/1ns
interface omsc_timer_if;
  logic start;
  logic active;
  modport timer (input start, output active);
  modport user  (output start, input active);
endinterface

// ### omsc_sync.sv
`timescale 1ns/1ns
module omsc_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } omsc_sync_t;

  omsc_sync_t cur_ff;
  omsc_sync_t nxt_ff;

  always_comb begin
    if (reset_i) begin
      nxt_ff = '{s1: INIT, s2: INIT};
    end else begin
      nxt_ff = '{s1: d_i, s2: cur_ff.s1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign q_o = cur_ff.s2;
endmodule

// ### omsc_pulse_timer.sv
`timescale 1ns/1ns
module omsc_pulse_timer
  import omsc_pkg::*;
#(
  parameter int DELAY_CYC = 0,
  parameter int PULSE_CYC = 1
) (
  input  wire logic     clk_i,
  input  wire logic     reset_i,
  input  wire logic     ce_i,
  omsc_timer_if.timer   tif
);
  omsc_timer_t cur_ff;
  omsc_timer_t nxt_ff;

  // a start while busy is dropped: one pulse per wake-up
  always_comb begin
    nxt_ff = cur_ff;
    if (reset_i) begin
      nxt_ff = '{phase: OMSC_T_IDLE, cnt: 20'h00000, active: 1'b0};
    end else begin
      case (cur_ff.phase)
        OMSC_T_IDLE: begin
          if (tif.start) begin
            if (DELAY_CYC > 0) begin
              nxt_ff.phase = OMSC_T_WAIT;
              nxt_ff.cnt   = 20'(DELAY_CYC - 1);
            end else begin
              nxt_ff.phase  = OMSC_T_PULSE;
              nxt_ff.cnt    = 20'(PULSE_CYC - 1);
              nxt_ff.active = 1'b1;
            end
          end
        end
        OMSC_T_WAIT: begin
          if (cur_ff.cnt == 20'h00000) begin
            nxt_ff.phase  = OMSC_T_PULSE;
            nxt_ff.cnt    = 20'(PULSE_CYC - 1);
            nxt_ff.active = 1'b1;
          end else begin
            nxt_ff.cnt = cur_ff.cnt - 20'h00001;
          end
        end
        OMSC_T_PULSE: begin
          if (cur_ff.cnt == 20'h00000) begin
            nxt_ff.phase  = OMSC_T_IDLE;
            nxt_ff.active = 1'b0;
          end else begin
            nxt_ff.cnt = cur_ff.cnt - 20'h00001;
          end
        end
        default: begin
          nxt_ff.phase  = OMSC_T_IDLE;
          nxt_ff.active = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || ce_i) begin
      cur_ff <= nxt_ff;
    end
  end

  assign tif.active = cur_ff.active;
endmodule

// ### omsc_host.sv
`timescale 1ns/1ns
module omsc_host (
  output logic sclk_o,
  output logic csn_o,
  output logic mosi_o
);
  initial begin
    sclk_o = 1'h0;
    csn_o  = 1'h1;
    mosi_o = 1'h0;
  end
  // msb first; clock rests low and still between frames
  task automatic send(input logic [7:0] f);
    csn_o = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = f[i];
      #80 sclk_o = 1'h1;
      #80 sclk_o = 1'h0;
    end
    // line released, no pull: show the inverse, not a stale bit
    mosi_o = ~f[0];
    #80 csn_o = 1'h1;
    #100;
  endtask
  // unlock goes out directly before the disable frame
  task automatic set_mon(input logic v, input logic [5:0] c1);
    send({2'h1, c1 | 6'h01});
    send({2'h2, 5'h00, v});
  endtask
  // open-load enables live outside this block; host has cleared them
  task automatic standby_request(input logic [1:0] b);
    send({2'h0, 4'h0, b});
  endtask
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
  logic       clk_i = 1'h0;
  logic       reset_i = 1'h1;
  logic       dbg_hi = 1'h0;
  logic       dbg_lo = 1'h1;
  logic       load_hi = 1'h0;
  logic       lin_wk = 1'h0;
  logic       tmr_wk = 1'h0;
  logic       err_clr = 1'h0;
  logic       ce = 1'h1;
  logic       can_wk = 1'h0;
  logic       sclk, csn, mosi;
  logic [1:0] mode, word;
  logic       wd_en, wd_rs, reg1, reg2, swa, swb, pout, lin_tx, can_tx;
  logic       int_n, rst_n, err, mon;
  int         err_total = 0;
  int         num_checks = 0;
  int         restarts = 0;
  int         cyc = 0;
  int         rs;

  always #2 clk_i = ~clk_i;

  omsc_top #(
    .REACT_CYC(4), .INT_PULSE_CYC(20), .RST_PULSE_CYC(30)
  ) omsc_top_i (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .link_sclk_i(sclk),
    .link_csn_i(csn), .link_mosi_i(mosi), .debug_high_i(dbg_hi),
    .debug_low_i(dbg_lo), .load_high_i(load_hi), .lin_wake_i(lin_wk),
    .can_wake_i(can_wk), .timer_wake_i(tmr_wk),
    .serial_error_clear_i(err_clr), .mode_o(mode),
    .standby_control_word_o(word), .watchdog_enable_o(wd_en),
    .watchdog_restart_o(wd_rs), .primary_regulator_on_o(reg1),
    .secondary_regulator_on_o(reg2), .always_on_switch_a_o(swa),
    .always_on_switch_b_o(swb), .power_outputs_on_o(pout),
    .lin_tx_enable_o(lin_tx), .can_tx_enable_o(can_tx),
    .wake_interrupt_n_o(int_n), .system_reset_out_n_o(rst_n),
    .serial_error_flag_o(err), .monitor_disable_o(mon));

  omsc_host omsc_host_i (.sclk_o(sclk), .csn_o(csn), .mosi_o(mosi));

  function automatic logic [7:0] outs();
    return {reg1, reg2, swa, swb, pout, lin_tx, can_tx, wd_en};
  endfunction

  task automatic end_sim();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // mid-cycle, so the one-cycle restart pulse is settled when counted
  always @(negedge clk_i) begin
    if (wd_rs === 1'h1) restarts++;
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("mismatch %0t timeout", $time);
      end_sim();
    end
  end

  // inputs move 1 ns after the edge so no race with the design
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_len(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      err_total++;
      $display("mismatch %0t pulse %0d exp %0d", $time, got, exp);
    end
  endtask

  // waits a bounded time for the low pulse, then counts its cycles
  task automatic pulse_len(input bit sel, input int exp);
    int w, n;
    w = 0;
    n = 0;
    while ((sel ? rst_n : int_n) !== 1'h0 && w < 200) begin
      tick(1);
      w++;
    end
    while ((sel ? rst_n : int_n) === 1'h0 && n < 1000) begin
      tick(1);
      n++;
    end
    chk_len(n, exp);
  endtask

  task automatic frame(input logic [7:0] f);
    omsc_host_i.send(f);
    tick(12);
  endtask

  initial begin
    tick(20);
    reset_i = 1'h0;
    tick(3);
    chk({6'h0, mode}, 8'h00);
    chk(outs(), 8'h87);
    frame(8'h01);
    chk({6'h0, mode}, 8'h00);
    frame(8'h5A);
    chk(outs(), 8'hEF);
    frame(8'h81);
    chk({7'h0, mon}, 8'h00);
    omsc_host_i.set_mon(1'h1, 6'h1A);
    tick(12);
    chk({7'h0, mon}, 8'h01);
    frame(8'h80);
    frame(8'h81);
    chk({7'h0, mon}, 8'h00);
    rs = restarts;
    omsc_host_i.standby_request(2'h3);
    tick(12);
    chk({6'h0, mode}, 8'h02);
    chk(outs(), 8'hE0);
    chk(8'(restarts - rs), 8'h01);
    rs = restarts;
    load_hi = 1'h1;
    tick(6);
    chk(outs(), 8'hE1);
    chk(8'(restarts - rs), 8'h01);
    load_hi = 1'h0;
    tick(6);
    chk(outs(), 8'hE0);
    lin_wk = 1'h1;
    pulse_len(1'b0, 20);
    lin_wk = 1'h0;
    chk({6'h0, mode}, 8'h00);
    chk({6'h0, word}, 8'h03);
    omsc_host_i.set_mon(1'h1, 6'h1A);
    rs = restarts;
    omsc_host_i.standby_request(2'h3);
    tick(12);
    chk(8'(restarts - rs), 8'h00);
    load_hi = 1'h1;
    tick(6);
    chk(outs(), 8'hE0);
    load_hi = 1'h0;
    frame(8'h5A);
    chk({6'h0, mode}, 8'h00);
    omsc_host_i.standby_request(2'h2);
    tick(12);
    chk(outs(), 8'h20);
    frame(8'h5A);
    chk({6'h0, mode}, 8'h03);
    tmr_wk = 1'h1;
    pulse_len(1'b1, 30);
    tmr_wk = 1'h0;
    chk({6'h0, mode}, 8'h00);
    frame(8'hC0);
    chk({5'h0, err, lin_tx, can_tx}, 8'h07);
    err_clr = 1'h1;
    tick(1);
    err_clr = 1'h0;
    tick(2);
    chk({7'h0, err}, 8'h00);
    // can wake disabled: no return from primary standby
    frame(8'hCD);
    omsc_host_i.standby_request(2'h3);
    tick(12);
    can_wk = 1'h1;
    tick(8);
    chk({6'h0, mode}, 8'h02);
    can_wk = 1'h0;
    frame(8'hCE);
    chk({6'h0, mode}, 8'h00);
    omsc_host_i.standby_request(2'h2);
    tick(12);
    can_wk = 1'h1;
    pulse_len(1'b1, 30);
    can_wk = 1'h0;
    chk({6'h0, mode}, 8'h00);
    // enable low: the debug pin must not be seen yet
    ce = 1'h0;
    dbg_hi = 1'h1;
    dbg_lo = 1'h0;
    tick(8);
    chk({6'h0, mode}, 8'h00);
    ce = 1'h1;
    tick(8);
    chk({5'h0, mode, can_tx}, 8'h03);
    chk({7'h0, wd_en}, 8'h00);
    rs = restarts;
    dbg_hi = 1'h0;
    dbg_lo = 1'h1;
    tick(8);
    chk({5'h0, mode, wd_en}, 8'h01);
    chk(8'(restarts - rs), 8'h01);
    end_sim();
  end
endmodule
